// *** cfg_pkg.sv ***
package cfg_pkg;
    localparam int CLK_MHZ = 100;
    localparam int WAIT_MIN_US = 50;
    localparam int WAIT_MAX_US = 250;
    // The least wait rounds up; the figure is already whole cycles at this rate.
    localparam int WAIT_CYCLES = WAIT_MIN_US * CLK_MHZ;
    localparam int CLEAR_CYCLES = 64;
    localparam int ADDR_W = 18;
    localparam int BYTE_W = 8;
    localparam logic [17:0] ADDR_TOP = 18'h3FFFF;
    localparam logic [17:0] ADDR_ZERO = 18'h00000;
    localparam int CONFIG_CLOCK_HALF = 4;
    localparam int LEN_W = 24;
    localparam int BYTE_TOP = 7;
    localparam logic [6:0] STATUS_FILL = 7'h7F;
    // Host strobe lengths cover the far end's two-flop input synchroniser.
    localparam logic [3:0] WR_HOLD = 4'h6;
    localparam logic [3:0] RD_HOLD = 4'h8;

    typedef enum logic [2:0] {
        MODE_MASTER_SERIAL,
        MODE_SLAVE_SERIAL,
        MODE_MASTER_PAR_UP,
        MODE_MASTER_PAR_DOWN,
        MODE_PERIPH_SYNC,
        MODE_PERIPH_ASYNC,
        MODE_EXPRESS
    } cfg_mode_e;

    typedef enum logic [1:0] {
        PH_CLEAR,
        PH_WAIT,
        PH_LOAD,
        PH_ACTIVE
    } phase_e;
endpackage

// *** cfg_port_if.sv ***
`timescale 1ns/1ps
interface cfg_port_if;
    logic config_clock_o_dev;
    logic config_clock_oe_dev;
    logic config_clock_o_host;
    logic config_clock_oe_host;
    logic init_o_dev;
    logic init_oe_dev;
    logic init_o_host;
    logic init_oe_host;
    logic config_pending_high;
    logic config_pending_low_n;
    logic select_low_n;
    logic select_high;
    logic write_strobe_n;
    logic read_strobe_n;
    logic program_n;
    logic [7:0] data_to_dev;
    logic [7:0] data_from_dev;
    logic data_oe_dev;
    logic serial_in;
    logic serial_out;
    logic ready_busy;
    logic [17:0] prom_address;
    logic scan_enabled;
    wire config_clock;
    wire init_n;
    assign config_clock = config_clock_oe_dev ? config_clock_o_dev :
                          config_clock_oe_host ? config_clock_o_host : 1'b1;
    assign init_n = (init_oe_dev && !init_o_dev) || (init_oe_host && !init_o_host) ? 1'b0 : 1'b1;

    modport device (
        output config_clock_o_dev, config_clock_oe_dev, init_o_dev, init_oe_dev,
        output config_pending_high, config_pending_low_n, data_from_dev, data_oe_dev,
        output serial_out, ready_busy, prom_address, scan_enabled,
        input config_clock, init_n, select_low_n, select_high, write_strobe_n,
        input read_strobe_n, program_n, data_to_dev, serial_in
    );
    modport host (
        output config_clock_o_host, config_clock_oe_host, init_o_host, init_oe_host,
        output select_low_n, select_high, write_strobe_n, read_strobe_n, program_n,
        output data_to_dev, serial_in,
        input config_clock, init_n, config_pending_high, config_pending_low_n,
        input data_from_dev, data_oe_dev, serial_out, ready_busy, prom_address
    );
endinterface

// *** sync2.sv ***
`timescale 1ns/1ps
module sync2 #(
    parameter int W = 1
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    if (W < 1) begin : g_bad_width
        $error("sync2: width must be positive");
    end

    logic [W-1:0] meta;
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            meta <= '0;
            q_o <= '0;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule

// *** cfg_device.sv ***
`timescale 1ns/1ps
// Summary of operation
// - High status output high until active.
// - Low status output low until active.
// - Drive clear/error low while clearing.
// - External low on clear/error holds waiting.
// - Master modes wait 50-250 us more.
// - Clear/error low reports data error.
// - Selected only when low-select low, high-select high.
// - Write strobe latches data byte.
// - Read strobe returns ready on top bit.
// - Write wins when both strobes low.
// - Fast parallel accepts bytes only when enabled.
// - Master parallel drives 18-bit PROM address.
// - Parallel modes take byte-wide data.
// - Serial modes sample on rising clock.
// - Serial output passes data downstream; here, outside fast parallel, it repeats serial input only once bits_in reaches LEN_BITS, else high.
// - Serial output changes on falling clock, except in fast parallel.
// - Fast parallel serial output enables next device.
// - No scan instance disables scan after load.
// - Ready/busy paces peripheral writes.
// - Reprogram low clears and restarts.
module cfg_device #(
    parameter int WAIT_CYC = cfg_pkg::WAIT_CYCLES,
    parameter int LEN_BITS = 64
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire cfg_pkg::cfg_mode_e mode_i,
    input wire logic scan_instance_i,
    input wire logic data_error_i,
    output logic user_active_o,
    output logic [7:0] load_byte_o,
    output logic load_byte_valid_o,
    cfg_port_if.device port
);
    if (WAIT_CYC < 1 || LEN_BITS < 8 || LEN_BITS % cfg_pkg::BYTE_W != 0) begin : g_bad_params
        $error("cfg_device: bad parameters");
    end

    // ====================================================================
    // Pin synchronisers
    // ====================================================================
    logic [15:0] pins_s;
    sync2 #(.W(16)) u_sync (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .d_i({port.config_clock, port.init_n, port.select_low_n, port.select_high,
              port.write_strobe_n, port.read_strobe_n, port.program_n, port.serial_in,
              port.data_to_dev}),
        .q_o(pins_s)
    );
    logic config_clock_s, init_s, cs0_s, cs1_s, ws_s, rs_s, prog_s, din_s;
    logic [7:0] d_s;
    assign {config_clock_s, init_s, cs0_s, cs1_s, ws_s, rs_s, prog_s, din_s, d_s} = pins_s;

    logic is_master, is_parallel, is_express, is_async, is_serial, drives_clk;
    assign is_master = mode_i == cfg_pkg::MODE_MASTER_SERIAL ||
                       mode_i == cfg_pkg::MODE_MASTER_PAR_UP ||
                       mode_i == cfg_pkg::MODE_MASTER_PAR_DOWN;
    assign is_express = mode_i == cfg_pkg::MODE_EXPRESS;
    assign is_async = mode_i == cfg_pkg::MODE_PERIPH_ASYNC;
    assign is_serial = mode_i == cfg_pkg::MODE_MASTER_SERIAL ||
                       mode_i == cfg_pkg::MODE_SLAVE_SERIAL;
    assign is_parallel = !is_serial;
    assign drives_clk = is_master || is_async;

    // ====================================================================
    // Phase sequencer
    // ====================================================================
    cfg_pkg::phase_e phase;
    logic [31:0] tmr;
    logic [31:0] bits_in;
    logic load_done;
    assign load_done = bits_in >= 32'(LEN_BITS);

    always_ff @(posedge ref_clk_i) begin
        if (srst_i || !prog_s) begin
            phase <= cfg_pkg::PH_CLEAR;
            tmr <= '0;
        end else begin
            case (phase)
                cfg_pkg::PH_CLEAR: begin
                    tmr <= tmr + 32'd1;
                    if (tmr >= 32'(cfg_pkg::CLEAR_CYCLES)) begin
                        phase <= cfg_pkg::PH_WAIT;
                        tmr <= '0;
                    end
                end
                cfg_pkg::PH_WAIT: begin
                    if (!init_s) begin
                        tmr <= '0;
                    end else if (!is_master || tmr >= 32'(WAIT_CYC)) begin
                        phase <= cfg_pkg::PH_LOAD;
                        tmr <= '0;
                    end else begin
                        tmr <= tmr + 32'd1;
                    end
                end
                cfg_pkg::PH_LOAD: begin
                    if (load_done && !data_error_i) phase <= cfg_pkg::PH_ACTIVE;
                end
                cfg_pkg::PH_ACTIVE: phase <= cfg_pkg::PH_ACTIVE;
                default: phase <= cfg_pkg::PH_CLEAR;
            endcase
        end
    end

    logic err;
    always_ff @(posedge ref_clk_i) begin
        if (srst_i || phase != cfg_pkg::PH_LOAD) err <= 1'b0;
        else if (data_error_i) err <= 1'b1;
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            port.config_pending_high <= 1'b1;
            port.config_pending_low_n <= 1'b0;
            port.init_o_dev <= 1'b0;
            port.init_oe_dev <= 1'b1;
            user_active_o <= 1'b0;
            port.scan_enabled <= 1'b1;
        end else begin
            port.config_pending_high <= phase != cfg_pkg::PH_ACTIVE;
            port.config_pending_low_n <= phase == cfg_pkg::PH_ACTIVE;
            port.init_o_dev <= 1'b0;
            port.init_oe_dev <= phase == cfg_pkg::PH_CLEAR || err;
            user_active_o <= phase == cfg_pkg::PH_ACTIVE;
            port.scan_enabled <= phase != cfg_pkg::PH_ACTIVE || scan_instance_i;
        end
    end

    // ====================================================================
    // Configuration clock: made here in master/async modes, else sampled
    // ====================================================================
    logic [7:0] div;
    logic config_clock_gen, config_clock_prev, config_clock_cur, rise, fall;
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            div <= '0;
            config_clock_gen <= 1'b1;
        end else if (div == 8'(cfg_pkg::CONFIG_CLOCK_HALF - 1)) begin
            div <= '0;
            config_clock_gen <= !config_clock_gen;
        end else begin
            div <= div + 8'd1;
        end
    end
    assign config_clock_cur = drives_clk ? config_clock_gen : config_clock_s;
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) config_clock_prev <= 1'b1;
        else config_clock_prev <= config_clock_cur;
    end
    assign rise = config_clock_cur && !config_clock_prev && phase == cfg_pkg::PH_LOAD;
    assign fall = !config_clock_cur && config_clock_prev;
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            port.config_clock_o_dev <= 1'b1;
            port.config_clock_oe_dev <= 1'b0;
        end else begin
            port.config_clock_o_dev <= config_clock_gen;
            port.config_clock_oe_dev <= drives_clk && phase == cfg_pkg::PH_LOAD;
        end
    end

    // ====================================================================
    // Byte intake and serialisation
    // ====================================================================
    logic selected, buf_full, wr_prev, wr_now;
    logic [7:0] shreg;
    logic [2:0] bitcnt;
    logic take_serial;
    assign selected = !cs0_s && cs1_s;
    assign wr_now = selected && !ws_s && is_async;
    assign take_serial = rise && is_serial;

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) wr_prev <= 1'b0;
        else wr_prev <= wr_now;
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i || phase != cfg_pkg::PH_LOAD) begin
            buf_full <= 1'b0;
            shreg <= '0;
            bitcnt <= '0;
            bits_in <= '0;
            load_byte_valid_o <= 1'b0;
            load_byte_o <= '0;
        end else begin
            load_byte_valid_o <= 1'b0;
            if (take_serial) begin
                shreg <= {shreg[6:0], din_s};
                bits_in <= bits_in + 32'd1;
                bitcnt <= bitcnt + 3'd1;
                if (bitcnt == 3'(cfg_pkg::BYTE_TOP)) begin
                    load_byte_o <= {shreg[6:0], din_s};
                    load_byte_valid_o <= 1'b1;
                end
            end else if (is_parallel && buf_full && rise) begin
                shreg <= {shreg[6:0], 1'b0};
                bits_in <= bits_in + 32'd1;
                bitcnt <= bitcnt + 3'd1;
                if (bitcnt == 3'(cfg_pkg::BYTE_TOP)) buf_full <= 1'b0;
            end else if (is_parallel && !buf_full) begin
                if ((is_async && wr_now && !wr_prev) ||
                    (is_express && cs1_s && rise) ||
                    (is_master && rise) ||
                    (mode_i == cfg_pkg::MODE_PERIPH_SYNC && selected && !ws_s && rise)) begin
                    shreg <= d_s;
                    load_byte_o <= d_s;
                    load_byte_valid_o <= 1'b1;
                    buf_full <= 1'b1;
                end
            end
        end
    end

    logic [17:0] addr;
    always_ff @(posedge ref_clk_i) begin
        if (srst_i || phase != cfg_pkg::PH_LOAD) begin
            addr <= mode_i == cfg_pkg::MODE_MASTER_PAR_DOWN ? cfg_pkg::ADDR_TOP
                                                             : cfg_pkg::ADDR_ZERO;
        end else if (is_master && is_parallel && rise && !buf_full) begin
            addr <= mode_i == cfg_pkg::MODE_MASTER_PAR_DOWN ? addr - 18'd1 : addr + 18'd1;
        end
    end

    // ====================================================================
    // Pin outputs
    // ====================================================================
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            port.prom_address <= cfg_pkg::ADDR_ZERO;
            port.ready_busy <= 1'b1;
            port.data_from_dev <= '1;
            port.data_oe_dev <= 1'b0;
            port.serial_out <= 1'b1;
        end else begin
            port.prom_address <= addr;
            port.ready_busy <= !buf_full;
            port.data_from_dev <= {!buf_full, cfg_pkg::STATUS_FILL};
            port.data_oe_dev <= is_async && selected && !rs_s && ws_s;
            if (is_express) begin
                port.serial_out <= phase != cfg_pkg::PH_LOAD || load_done;
            end else if (fall) begin
                port.serial_out <= load_done ? din_s : 1'b1;
            end
        end
    end
endmodule

// *** cfg_host.sv ***
`timescale 1ns/1ps
module cfg_host (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic reprogram_i,
    input wire logic hold_wait_i,
    input wire logic wr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic rd_i,
    output logic [7:0] rd_data_o,
    output logic ready_o,
    output logic done_o,
    cfg_port_if.host port
);
    // A write is only offered once the far end has left clearing, so no byte is lost.
    logic [2:0] pins_s;
    sync2 #(.W(3)) u_sync (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .d_i({port.ready_busy, port.config_pending_low_n, port.init_n}),
        .q_o(pins_s)
    );
    logic [7:0] rd_s;
    sync2 #(.W(8)) u_sync_d (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .d_i(port.data_from_dev),
        .q_o(rd_s)
    );

    // Writes are held for several cycles so the device's synchroniser sees them.
    logic [3:0] hold;
    logic rd_pend;
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            port.select_low_n <= 1'b1;
            port.select_high <= 1'b0;
            port.write_strobe_n <= 1'b1;
            port.read_strobe_n <= 1'b1;
            port.data_to_dev <= '0;
            hold <= '0;
            rd_pend <= 1'b0;
            rd_data_o <= '0;
        end else if (hold != 4'h0) begin
            hold <= hold - 4'h1;
            if (hold == 4'h1) begin
                port.select_low_n <= 1'b1;
                port.select_high <= 1'b0;
                port.write_strobe_n <= 1'b1;
                port.read_strobe_n <= 1'b1;
                if (rd_pend) rd_data_o <= rd_s;
                rd_pend <= 1'b0;
            end
        end else if (wr_i && pins_s[2] && pins_s[0]) begin
            port.select_low_n <= 1'b0;
            port.select_high <= 1'b1;
            port.write_strobe_n <= 1'b0;
            port.data_to_dev <= wr_data_i;
            hold <= cfg_pkg::WR_HOLD;
        end else if (rd_i) begin
            port.select_low_n <= 1'b0;
            port.select_high <= 1'b1;
            port.read_strobe_n <= 1'b0;
            rd_pend <= 1'b1;
            hold <= cfg_pkg::RD_HOLD;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            port.program_n <= 1'b1;
            port.init_o_host <= 1'b0;
            port.init_oe_host <= 1'b0;
            port.config_clock_o_host <= 1'b1;
            port.config_clock_oe_host <= 1'b0;
            port.serial_in <= 1'b1;
            ready_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            port.program_n <= !reprogram_i;
            port.init_oe_host <= hold_wait_i;
            ready_o <= pins_s[2] && pins_s[0] && hold == 4'h0;
            done_o <= pins_s[1];
        end
    end
endmodule

// *** cfg_port_checker.sv ***
`timescale 1ns/1ps
// ============================================================
// Port checker for the configuration interface
module cfg_port_checker (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic config_clock,
    input wire logic init_n,
    input wire logic config_pending_high,
    input wire logic config_pending_low_n,
    input wire logic select_low_n,
    input wire logic select_high,
    input wire logic write_strobe_n,
    input wire logic read_strobe_n,
    input wire logic program_n,
    input wire logic [7:0] data_from_dev,
    input wire logic data_oe_dev,
    input wire logic serial_out,
    input wire logic ready_busy,
    input wire logic scan_enabled
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (srst_i);

    wire selected = !select_low_n && select_high;

    sequence s_read_held;
        (selected && !read_strobe_n && write_strobe_n && config_pending_high)[*4];
    endsequence
    sequence s_write_start;
        selected && config_pending_high && $fell(write_strobe_n);
    endsequence
    sequence s_prog_held;
        !program_n[*3];
    endsequence

    property p_pending_pair;
        config_pending_high != config_pending_low_n;
    endproperty
    property p_clear_after_reset;
        $fell(srst_i) |-> !init_n;
    endproperty
    property p_wait_holds_pending;
        !init_n |-> config_pending_high;
    endproperty
    property p_read_status;
        s_read_held |-> data_oe_dev && data_from_dev[6:0] == cfg_pkg::STATUS_FILL;
    endproperty
    property p_no_drive_unselected;
        (!selected)[*4] |-> !data_oe_dev;
    endproperty
    property p_write_wins;
        (selected && !write_strobe_n)[*4] |-> !data_oe_dev;
    endproperty
    property p_busy_after_write;
        s_write_start |-> ##[1:8] !ready_busy;
    endproperty
    property p_dout_on_low_clock;
        $changed(serial_out) && config_pending_high |-> !config_clock;
    endproperty
    property p_scan_during_config;
        config_pending_high |-> scan_enabled;
    endproperty
    property p_program_clears;
        s_prog_held |-> ##[0:4] (config_pending_high && !init_n);
    endproperty

    a_pending_pair: assert property (p_pending_pair)
        else $error("pending outputs not complementary");
    a_clear_after_reset: assert property (p_clear_after_reset)
        else $error("clear signal not low after reset");
    a_wait_holds_pending: assert property (p_wait_holds_pending)
        else $error("configuration ended while clear signal low");
    a_read_status: assert property (p_read_status)
        else $error("status read not driven as expected");
    a_no_drive_unselected: assert property (p_no_drive_unselected)
        else $error("data driven while not selected");
    a_write_wins: assert property (p_write_wins)
        else $error("data driven during a write");
    a_busy_after_write: assert property (p_busy_after_write)
        else $error("no busy after a write");
    a_dout_on_low_clock: assert property (p_dout_on_low_clock)
        else $error("serial output changed with clock high");
    a_scan_during_config: assert property (p_scan_during_config)
        else $error("scan disabled during configuration");
    a_program_clears: assert property (p_program_clears)
        else $error("reprogram did not clear");
endmodule

// *** testbench.sv ***
`timescale 1ns/1ps
// ============================================================
// Top level: both ends joined, host side driven by tasks
module testbench;
    logic ref_clk;
    logic srst;
    logic reprogram;
    logic hold_wait;
    logic wr;
    logic [7:0] wr_data;
    logic rd;
    logic [7:0] rd_data;
    logic host_ready;
    logic host_done;
    logic data_error;
    logic user_active;
    logic [7:0] load_byte;
    logic load_byte_valid;
    logic [17:0] last_addr;
    cfg_pkg::cfg_mode_e mode;
    logic [7:0] got_q[$];
    logic [7:0] pat [8] = '{8'h00, 8'hFF, 8'hA5, 8'h5A, 8'h01, 8'h80, 8'h7E, 8'hC3};
    int miscompares;
    int comparisons;

    cfg_port_if cfg_port_if_inst();
    // The master wait is shortened so the run stays brief.
    cfg_device #(.WAIT_CYC(20), .LEN_BITS(64)) cfg_device_inst (
        .ref_clk_i(ref_clk), .srst_i(srst), .mode_i(mode),
        .scan_instance_i(1'b0), .data_error_i(data_error), .user_active_o(user_active),
        .load_byte_o(load_byte), .load_byte_valid_o(load_byte_valid),
        .port(cfg_port_if_inst.device));
    cfg_host cfg_host_inst (
        .ref_clk_i(ref_clk), .srst_i(srst), .reprogram_i(reprogram), .hold_wait_i(hold_wait),
        .wr_i(wr), .wr_data_i(wr_data), .rd_i(rd), .rd_data_o(rd_data), .ready_o(host_ready),
        .done_o(host_done), .port(cfg_port_if_inst.host));
    cfg_port_checker cfg_port_checker_inst (
        .ref_clk_i(ref_clk), .srst_i(srst), .config_clock(cfg_port_if_inst.config_clock),
        .init_n(cfg_port_if_inst.init_n),
        .config_pending_high(cfg_port_if_inst.config_pending_high),
        .config_pending_low_n(cfg_port_if_inst.config_pending_low_n),
        .select_low_n(cfg_port_if_inst.select_low_n),
        .select_high(cfg_port_if_inst.select_high),
        .write_strobe_n(cfg_port_if_inst.write_strobe_n),
        .read_strobe_n(cfg_port_if_inst.read_strobe_n),
        .program_n(cfg_port_if_inst.program_n),
        .data_from_dev(cfg_port_if_inst.data_from_dev),
        .data_oe_dev(cfg_port_if_inst.data_oe_dev), .serial_out(cfg_port_if_inst.serial_out),
        .ready_busy(cfg_port_if_inst.ready_busy), .scan_enabled(cfg_port_if_inst.scan_enabled));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        if (load_byte_valid === 1'b1) begin
            got_q.push_back(load_byte);
            last_addr <= cfg_port_if_inst.prom_address;
        end
    end

    // ============================================================
    // Shared tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] expected);
        comparisons++;
        if (seen !== expected) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, expected);
        end
    endtask

    function automatic logic pick(input int which);
        case (which)
            0: return host_ready;
            1: return user_active;
            3: return host_done;
            default: return cfg_port_if_inst.init_n;
        endcase
    endfunction

    // A bounded poll, so a stuck handshake shows as a mismatch instead of a hang.
    // Polled on the falling edge, where every registered output has settled.
    task automatic wait_sig(input int which, input logic level);
        int n;
        n = 0;
        @(negedge ref_clk);
        while (pick(which) !== level && n < 3000) begin
            @(negedge ref_clk);
            n++;
        end
        check({7'h00, pick(which)}, {7'h00, level});
    endtask

    task automatic write_byte(input logic [7:0] d);
        wait_sig(0, 1'b1);
        @(posedge ref_clk);
        wr <= 1'b1;
        wr_data <= d;
        @(posedge ref_clk);
        wr <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask

    task automatic read_status();
        wait_sig(0, 1'b1);
        @(posedge ref_clk);
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        repeat (4) @(posedge ref_clk);
        wait_sig(0, 1'b1);
        check(rd_data, 8'hFF);
    endtask

    task automatic pending(input logic [7:0] expected);
        check({5'h00, cfg_port_if_inst.scan_enabled, cfg_port_if_inst.config_pending_high,
               cfg_port_if_inst.config_pending_low_n}, expected);
    endtask

    task automatic summarize();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ============================================================
    // Test sequence
    initial begin
        srst = 1'b1;
        mode = cfg_pkg::MODE_PERIPH_ASYNC;
        reprogram = 1'b0;
        hold_wait = 1'b0;
        wr = 1'b0;
        wr_data = 8'h00;
        rd = 1'b0;
        data_error = 1'b0;
        miscompares = 0;
        comparisons = 0;
        repeat (20) @(posedge ref_clk);
        srst <= 1'b0;
        hold_wait <= 1'b1;
        @(posedge ref_clk);
        check({7'h00, cfg_port_if_inst.init_n}, 8'h00);
        repeat (200) @(posedge ref_clk);
        check({7'h00, cfg_port_if_inst.init_n}, 8'h00);
        pending(8'h06);
        hold_wait <= 1'b0;
        read_status();
        foreach (pat[i]) begin
            write_byte(pat[i]);
        end
        wait_sig(1, 1'b1);
        check(8'(got_q.size()), 8'h08);
        foreach (pat[i]) begin
            if (i < got_q.size()) check(got_q[i], pat[i]);
        end
        pending(8'h01);
        wait_sig(3, 1'b1);
        @(posedge ref_clk);
        reprogram <= 1'b1;
        repeat (10) @(posedge ref_clk);
        reprogram <= 1'b0;
        check({6'h00, user_active, cfg_port_if_inst.config_pending_high}, 8'h01);
        write_byte(8'h3C);
        data_error <= 1'b1;
        wait_sig(2, 1'b0);
        pending(8'h06);
        @(posedge ref_clk);
        data_error <= 1'b0;
        srst <= 1'b1;
        mode <= cfg_pkg::MODE_MASTER_PAR_UP;
        repeat (20) @(posedge ref_clk);
        srst <= 1'b0;
        got_q.delete();
        @(posedge ref_clk);
        pending(8'h06);
        wait_sig(2, 1'b1);
        repeat (15) @(posedge ref_clk);
        check(8'(got_q.size()), 8'h00);
        wait_sig(1, 1'b1);
        check(8'(got_q.size()), 8'h08);
        check(last_addr[7:0], 8'h07);
        foreach (got_q[i]) check(got_q[i], 8'h00);
        summarize();
    end

    initial begin
        repeat (40000) @(posedge ref_clk);
        miscompares++;
        $display("[FAIL] %0t watchdog expired", $time);
        summarize();
    end
endmodule
